// ===== core/late_write_sram.sv
/*
 * synchronous late-write static ram core with byte writes, asynchronous
 * output gate, sleep input and boundary-scan port.
 * assumes every pin is asynchronous to ref_clk and that the sram clock
 * pair runs well below a quarter of ref_clk.
 */
module late_write_sram #(
    parameter int LANES = sram_pkg::NARROW_LANES,
    parameter int ADDR_W = sram_pkg::NARROW_ADDR_W,
    parameter logic [sram_pkg::ID_W-1:0] ID_VALUE = sram_pkg::ID_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ck_p,
    input wire logic ck_n,
    input wire logic [ADDR_W-1:0] sync_address,
    input wire logic select_n,
    input wire logic write_enable_n,
    input wire logic [LANES-1:0] byte_write_enable_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [LANES*sram_pkg::LANE_W-1:0] data_lane_in,
    output logic [LANES*sram_pkg::LANE_W-1:0] data_lane_out,
    output logic data_lane_oe_n,
    output logic sleep_active,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_out,
    output logic tdo_oe_n
);
    // word count and width follow the build
    localparam int DW = LANES * sram_pkg::LANE_W;
    localparam int DEPTH = 2 ** ADDR_W;
    // single-bit pins in the synchroniser bundle
    localparam int CTRL_PINS = 5;
    localparam int PIN_W = CTRL_PINS + LANES + ADDR_W + DW;

    logic [PIN_W-1:0] meta_r;
    logic [PIN_W-1:0] sync_r;
    logic ck_p_s, ck_n_s, sel_n_s, we_n_s, sleep_s;
    logic [LANES-1:0] be_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DW-1:0] din_s;
    logic ck_high, ck_prev_r, ck_rise, access;

    logic pend_wr_r, pend_wr_nxt;
    logic [ADDR_W-1:0] pend_addr_r, pend_addr_nxt;
    logic [LANES-1:0] pend_be_r, pend_be_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic [DW-1:0] dout_r, dout_nxt;
    logic drive_r, drive_nxt;
    logic sleep_r, sleep_nxt;
    logic [DW-1:0] mem [DEPTH];

    // lane-masked merge of new data into a stored word
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                            input logic [DW-1:0] new_w,
                                            input logic [LANES-1:0] be);
        merge = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (be[i]) begin
                merge[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
                    new_w[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
            end
        end
    endfunction

    // two-stage synchroniser for every sram pin except output_enable_n
    always_ff @(posedge ref_clk) begin
        meta_r <= {ck_p, ck_n, select_n, write_enable_n, sleep_request,
                   byte_write_enable_n, sync_address, data_lane_in};
        sync_r <= meta_r;
    end

    assign {ck_p_s, ck_n_s, sel_n_s, we_n_s, sleep_s, be_n_s, addr_s,
            din_s} = sync_r;

    assign ck_high = ck_p_s & ~ck_n_s;
    assign ck_rise = ck_high & ~ck_prev_r;
    assign access = ~sel_n_s & ~sleep_s;

    always_comb begin
        pend_wr_nxt = pend_wr_r;
        pend_addr_nxt = pend_addr_r;
        pend_be_nxt = pend_be_r;
        rd_pend_nxt = rd_pend_r;
        rd_addr_nxt = rd_addr_r;
        dout_nxt = dout_r;
        drive_nxt = drive_r;
        sleep_nxt = sleep_s;
        if (ck_rise) begin
            pend_wr_nxt = access & ~we_n_s;
            pend_addr_nxt = addr_s;
            // byte enables only kept for writes
            pend_be_nxt = we_n_s ? '0 : ~be_n_s;
            rd_pend_nxt = access & we_n_s;
            rd_addr_nxt = addr_s;
            // launch read data on the rise
            drive_nxt = rd_pend_r;
            if (rd_pend_r) begin
                dout_nxt = mem[rd_addr_r];
            end
        end
        if (sleep_s) begin
            drive_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ck_prev_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_addr_r <= '0;
            pend_be_r <= '0;
            rd_pend_r <= 1'b0;
            rd_addr_r <= '0;
            dout_r <= '0;
            drive_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            ck_prev_r <= ck_high;
            pend_wr_r <= pend_wr_nxt;
            pend_addr_r <= pend_addr_nxt;
            pend_be_r <= pend_be_nxt;
            rd_pend_r <= rd_pend_nxt;
            rd_addr_r <= rd_addr_nxt;
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
            sleep_r <= sleep_nxt;
        end
    end

    // late data captured one rise later
    always_ff @(posedge ref_clk) begin
        if (reset_n && ck_rise && pend_wr_r) begin
            mem[pend_addr_r] <= merge(mem[pend_addr_r], din_s, pend_be_r);
        end
    end

    assign data_lane_out = dout_r;
    assign data_lane_oe_n = output_enable_n | ~drive_r;
    assign sleep_active = sleep_r;

    scan_port #(
        .ID_VALUE(ID_VALUE)
    ) i_scan_port (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo_out(tdo_out),
        .tdo_oe_n(tdo_oe_n)
    );

    read_sample_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && access && we_n_s |=> rd_pend_r &&
            rd_addr_r == $past(addr_s))
        else $error("read request not sampled at clock rise");

    addr_hold_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && access && !we_n_s |=> pend_addr_r == $past(addr_s))
        else $error("write address not sampled at clock rise");

    late_write_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r && (&pend_be_r) |=>
            mem[$past(pend_addr_r)] == $past(din_s))
        else $error("late write data not stored");

    read_launch_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $changed(data_lane_out) |-> $past(ck_rise) && $past(rd_pend_r))
        else $error("read data changed outside a clock rise");

    read_data_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && rd_pend_r |=> data_lane_out == $past(mem[rd_addr_r]))
        else $error("launched read data differs from the stored word");

    drive_launch_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && rd_pend_r && !sleep_s |=> drive_r)
        else $error("read data not driven after launch");

    diff_edge_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise |-> ck_p_s && !ck_n_s && !$past(ck_high))
        else $error("clock rise without differential edge");

    lane_hold_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r && !pend_be_r[0] |=>
            mem[$past(pend_addr_r)][sram_pkg::LANE_W-1:0] ==
            $past(mem[pend_addr_r][sram_pkg::LANE_W-1:0]))
        else $error("disabled lane was written");

    top_lane_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r && !pend_be_r[LANES-1] |=>
            mem[$past(pend_addr_r)][DW-1 -: sram_pkg::LANE_W] ==
            $past(mem[pend_addr_r][DW-1 -: sram_pkg::LANE_W]))
        else $error("disabled top lane was written");

    lane_write_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r && pend_be_r[0] |=>
            mem[$past(pend_addr_r)][sram_pkg::LANE_W-1:0] ==
            $past(din_s[sram_pkg::LANE_W-1:0]))
        else $error("enabled lane missed its write data");

    write_strobe_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && access && !we_n_s |=> pend_wr_r &&
            pend_be_r == ~$past(be_n_s) ##0 !rd_pend_r)
        else $error("registered write did not arm all enabled lanes");

    be_ignore_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && we_n_s |=> !pend_wr_r && pend_be_r == '0)
        else $error("byte enables acted during a read cycle");

    deselect_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && sel_n_s |=> !pend_wr_r && !rd_pend_r)
        else $error("deselected cycle started an access");

    idle_float_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && !rd_pend_r |=> !drive_r)
        else $error("drivers left on after a non-read rise");

    oe_gate_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        output_enable_n |-> data_lane_oe_n)
        else $error("drivers on while output enable high");

    gate_open_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        drive_r && !output_enable_n |-> !data_lane_oe_n)
        else $error("drivers off while gate open and read launched");

    sleep_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        sleep_s |=> !drive_r && sleep_active)
        else $error("drivers on or flag low during sleep");

    sleep_wake_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !sleep_s |=> !sleep_active)
        else $error("sleep flag high after sleep input dropped");

    sleep_cancel_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && sleep_s |=> !pend_wr_r && !rd_pend_r)
        else $error("access started while asleep");

    write_float_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r |=> data_lane_oe_n)
        else $error("data driven during write cycle");

    read_cycle_c: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && rd_pend_r ##1 !data_lane_oe_n);
    byte_write_c: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && pend_wr_r && !(&pend_be_r) && (|pend_be_r));
    sleep_entry_c: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        drive_r ##1 sleep_active);

    // gate and deselect scenarios reached
    gate_block_c: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        drive_r && output_enable_n);
    deselect_c: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        ck_rise && sel_n_s && !sleep_s);
endmodule // late_write_sram

// ===== core/sram_pkg.sv
/*
 * constants shared by the late-write sram core and its test access port.
 * assumes nothing of its surroundings; definitions only.
 */
package sram_pkg;
    // data lane width in bits
    localparam int LANE_W = 9;
    // narrow build: 256k words of 18 bits
    localparam int NARROW_LANES = 2;
    localparam int NARROW_ADDR_W = 18;
    // wide build: 128k words of 36 bits
    localparam int WIDE_LANES = 4;
    localparam int WIDE_ADDR_W = 17;
    // pin synchroniser depth
    localparam int SYNC_STAGES = 2;
    // test access port
    localparam int IR_W = 2;
    localparam logic [IR_W-1:0] IR_IDCODE = 2'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 2'h3;
    localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
    localparam int ID_W = 32;
    // arbitrary identity value, names no maker or part
    localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
        TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_e;
endpackage

// ===== core/scan_port.sv
/*
 * boundary-scan test access port: state machine, instruction register,
 * bypass and identity data registers.
 * assumes test pins are asynchronous to ref_clk and far slower than it.
 */
module scan_port #(
    parameter logic [sram_pkg::ID_W-1:0] ID_VALUE = sram_pkg::ID_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_out,
    output logic tdo_oe_n
);
    logic [2:0] meta_r;
    logic [2:0] pin_r;
    logic tck_prev_r;
    logic tck_rise;
    logic tck_fall;
    sram_pkg::tap_state_e state_r, state_nxt;
    logic [sram_pkg::IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic [sram_pkg::ID_W-1:0] dr_r, dr_nxt;
    logic tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;

    function automatic sram_pkg::tap_state_e step(
        input sram_pkg::tap_state_e s, input logic m);
        unique case (s)
            sram_pkg::TAP_RESET: step = m ? sram_pkg::TAP_RESET
                                           : sram_pkg::TAP_IDLE;
            sram_pkg::TAP_IDLE, sram_pkg::TAP_UPD_DR, sram_pkg::TAP_UPD_IR:
                step = m ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
            sram_pkg::TAP_SEL_DR: step = m ? sram_pkg::TAP_SEL_IR
                                           : sram_pkg::TAP_CAP_DR;
            sram_pkg::TAP_CAP_DR, sram_pkg::TAP_SHIFT_DR,
            sram_pkg::TAP_EXIT2_DR:
                step = m ? sram_pkg::TAP_EXIT1_DR : sram_pkg::TAP_SHIFT_DR;
            sram_pkg::TAP_EXIT1_DR: step = m ? sram_pkg::TAP_UPD_DR
                                             : sram_pkg::TAP_PAUSE_DR;
            sram_pkg::TAP_PAUSE_DR: step = m ? sram_pkg::TAP_EXIT2_DR
                                             : sram_pkg::TAP_PAUSE_DR;
            sram_pkg::TAP_SEL_IR: step = m ? sram_pkg::TAP_RESET
                                           : sram_pkg::TAP_CAP_IR;
            sram_pkg::TAP_CAP_IR, sram_pkg::TAP_SHIFT_IR,
            sram_pkg::TAP_EXIT2_IR:
                step = m ? sram_pkg::TAP_EXIT1_IR : sram_pkg::TAP_SHIFT_IR;
            sram_pkg::TAP_EXIT1_IR: step = m ? sram_pkg::TAP_UPD_IR
                                             : sram_pkg::TAP_PAUSE_IR;
            sram_pkg::TAP_PAUSE_IR: step = m ? sram_pkg::TAP_EXIT2_IR
                                             : sram_pkg::TAP_PAUSE_IR;
        endcase
    endfunction

    assign tck_rise = pin_r[2] & ~tck_prev_r;
    assign tck_fall = ~pin_r[2] & tck_prev_r;

    always_comb begin
        state_nxt = state_r;
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        dr_nxt = dr_r;
        tdo_nxt = tdo_r;
        oe_n_nxt = oe_n_r;
        if (tck_rise) begin
            state_nxt = step(state_r, pin_r[1]);
            unique case (state_r)
                sram_pkg::TAP_RESET: ir_nxt = sram_pkg::IR_IDCODE;
                sram_pkg::TAP_CAP_IR: ir_sh_nxt = sram_pkg::IR_CAPTURE;
                sram_pkg::TAP_SHIFT_IR:
                    ir_sh_nxt = {pin_r[0], ir_sh_r[sram_pkg::IR_W-1:1]};
                sram_pkg::TAP_UPD_IR: ir_nxt = ir_sh_r;
                sram_pkg::TAP_CAP_DR:
                    dr_nxt = (ir_r == sram_pkg::IR_IDCODE) ? ID_VALUE
                                                           : '0;
                sram_pkg::TAP_SHIFT_DR:
                    if (ir_r == sram_pkg::IR_IDCODE) begin
                        dr_nxt = {pin_r[0], dr_r[sram_pkg::ID_W-1:1]};
                    end else begin
                        dr_nxt = {{(sram_pkg::ID_W-1){1'b0}}, pin_r[0]};
                    end
                default: ;
            endcase
        end
        // output changes on the falling test clock
        if (tck_fall) begin
            oe_n_nxt = ~(state_r == sram_pkg::TAP_SHIFT_DR ||
                         state_r == sram_pkg::TAP_SHIFT_IR);
            tdo_nxt = (state_r == sram_pkg::TAP_SHIFT_IR) ? ir_sh_r[0]
                                                           : dr_r[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        meta_r <= {tck, tms, tdi};
        pin_r <= meta_r;
        if (!reset_n) begin
            tck_prev_r <= 1'b0;
            state_r <= sram_pkg::TAP_RESET;
            ir_sh_r <= '0;
            ir_r <= sram_pkg::IR_IDCODE;
            dr_r <= '0;
            tdo_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            tck_prev_r <= pin_r[2];
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
            dr_r <= dr_nxt;
            tdo_r <= tdo_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign tdo_out = tdo_r;
    assign tdo_oe_n = oe_n_r;
endmodule // scan_port

// ===== tb/sram_host.sv
/*
 * behavioural cache controller driving the sram pins.
 * assumes the sram clock pair is made here, about 11 ref_clk per period.
 */
module sram_host #(
    parameter int AW = 4,
    parameter int LN = 2
) (
    input wire logic ref_clk,
    output logic ck_p,
    output logic ck_n,
    output logic [AW-1:0] sync_address,
    output logic select_n,
    output logic write_enable_n,
    output logic [LN-1:0] byte_write_enable_n,
    output logic output_enable_n,
    output logic sleep_request,
    output logic [LN*sram_pkg::LANE_W-1:0] data_lane_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ck_p = 1'h0;
        ck_n = 1'h1;
        sync_address = '0;
        select_n = 1'h1;
        write_enable_n = 1'h1;
        byte_write_enable_n = '1;
        output_enable_n = 1'h0;
        sleep_request = 1'h0;
        data_lane_in = '0;
    end

    // one sram clock period; d is late data for the previous access
    task automatic xfer(input logic [AW-1:0] a, input logic sel,
                        input logic we, input logic [LN-1:0] be,
                        input logic [LN*sram_pkg::LANE_W-1:0] d,
                        input logic good_ck);
        @(negedge ref_clk);
        sync_address = a;
        select_n = sel;
        write_enable_n = we;
        byte_write_enable_n = be;
        data_lane_in = d;
        repeat (2) @(negedge ref_clk);
        ck_p = 1'h1;
        ck_n = ~good_ck;
        repeat (4) @(negedge ref_clk);
        ck_p = 1'h0;
        ck_n = 1'h1;
        // released data shows its inverse
        data_lane_in = ~d;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic set_gate(input logic v);
        @(negedge ref_clk);
        output_enable_n = v;
    endtask

    task automatic set_sleep(input logic v);
        @(negedge ref_clk);
        sleep_request = v;
    endtask
endmodule // sram_host

// ===== tb/late_write_sram_tb_top.sv
/*
 * self-checking bench for the late-write sram core, narrow lane count with 16 words.
 * assumes sram_host drives the sram pins; scan pins are driven here.
 */
module late_write_sram_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 4;
    localparam int LN = 2;
    localparam int DW = LN * sram_pkg::LANE_W;
    // arbitrary identity value
    localparam logic [31:0] ID_TEST = 32'h5a3c_0f96;
    localparam logic [DW-1:0] WORD_A = 18'h2_a5c3;
    localparam logic [DW-1:0] WORD_B = 18'h2_a411;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic ck_p, ck_n, select_n, write_enable_n, output_enable_n;
    logic sleep_request, data_lane_oe_n, sleep_active;
    logic [AW-1:0] sync_address;
    logic [LN-1:0] byte_write_enable_n;
    logic [DW-1:0] data_lane_in, data_lane_out;
    logic tck = 1'h0;
    logic tms = 1'h1;
    logic tdi = 1'h0;
    logic tdo_out, tdo_oe_n;
    int mismatches = 0;
    int total_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    sram_host #(.AW(AW), .LN(LN)) i_sram_host (.ref_clk(ref_clk),
        .ck_p(ck_p), .ck_n(ck_n), .sync_address(sync_address),
        .select_n(select_n), .write_enable_n(write_enable_n),
        .byte_write_enable_n(byte_write_enable_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .data_lane_in(data_lane_in));

    late_write_sram #(.LANES(LN), .ADDR_W(AW), .ID_VALUE(ID_TEST))
    i_late_write_sram (.ref_clk(ref_clk), .reset_n(reset_n), .ck_p(ck_p),
        .ck_n(ck_n), .sync_address(sync_address), .select_n(select_n),
        .write_enable_n(write_enable_n),
        .byte_write_enable_n(byte_write_enable_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .data_lane_in(data_lane_in), .data_lane_out(data_lane_out),
        .data_lane_oe_n(data_lane_oe_n), .sleep_active(sleep_active),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
        .tdo_oe_n(tdo_oe_n));

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // read with byte enables all low, then an idle cycle to launch it
    task automatic read_word(input logic [AW-1:0] a,
                             input logic [DW-1:0] exp);
        i_sram_host.xfer(a, 1'h0, 1'h1, 2'h0, 18'h0, 1'h1);
        i_sram_host.xfer(4'h0, 1'h1, 1'h1, 2'h3, 18'h0, 1'h1);
        chk_val("read data", {14'h0, exp}, {14'h0, data_lane_out});
        chk_bit("read driving", 1'h0, data_lane_oe_n);
    endtask

    task automatic t_write_read();
        i_sram_host.xfer(4'h3, 1'h0, 1'h0, 2'h0, 18'h0, 1'h1);
        i_sram_host.xfer(4'h3, 1'h0, 1'h1, 2'h3, WORD_A, 1'h1);
        chk_bit("write floats bus", 1'h1, data_lane_oe_n);
        i_sram_host.xfer(4'h0, 1'h1, 1'h1, 2'h3, 18'h0, 1'h1);
        chk_val("back to back", 32'(WORD_A), 32'(data_lane_out));
        i_sram_host.set_gate(1'h1);
        #1;
        chk_bit("gate off", 1'h1, data_lane_oe_n);
        i_sram_host.set_gate(1'h0);
        #1;
        chk_bit("gate on", 1'h0, data_lane_oe_n);
        i_sram_host.xfer(4'h0, 1'h1, 1'h1, 2'h3, 18'h0, 1'h1);
        chk_bit("deselect floats", 1'h1, data_lane_oe_n);
    endtask

    task automatic t_byte_lanes();
        i_sram_host.xfer(4'h3, 1'h0, 1'h0, 2'h3, 18'h0, 1'h1);
        i_sram_host.xfer(4'h3, 1'h0, 1'h0, 2'h2, 18'h3_ffff, 1'h1);
        i_sram_host.xfer(4'h5, 1'h1, 1'h1, 2'h3, 18'h0_0011, 1'h1);
        read_word(4'h3, WORD_B);
        read_word(4'h3, WORD_B);
    endtask

    task automatic t_ignored();
        i_sram_host.xfer(4'h3, 1'h1, 1'h0, 2'h0, 18'h0, 1'h1);
        i_sram_host.xfer(4'h3, 1'h0, 1'h0, 2'h0, 18'h0, 1'h0);
        i_sram_host.xfer(4'h3, 1'h1, 1'h1, 2'h3, 18'h0, 1'h1);
        read_word(4'h3, WORD_B);
        read_word(4'h3, WORD_B);
    endtask

    task automatic t_sleep();
        int n;
        i_sram_host.set_sleep(1'h1);
        for (n = 0; n < 10 && sleep_active !== 1'h1; n++) begin
            @(negedge ref_clk);
        end
        chk_bit("sleep entered", 1'h1, sleep_active);
        i_sram_host.xfer(4'h3, 1'h0, 1'h0, 2'h0, 18'h0, 1'h1);
        i_sram_host.xfer(4'h3, 1'h0, 1'h1, 2'h3, 18'h0, 1'h1);
        i_sram_host.xfer(4'h0, 1'h1, 1'h1, 2'h3, 18'h0, 1'h1);
        chk_bit("sleep floats", 1'h1, data_lane_oe_n);
        i_sram_host.set_sleep(1'h0);
        for (n = 0; n < 10 && sleep_active !== 1'h0; n++) begin
            @(negedge ref_clk);
        end
        chk_bit("sleep left", 1'h0, sleep_active);
        read_word(4'h3, WORD_B);
    endtask

    task automatic scan_step(input logic m, output logic seen);
        tms = m;
        repeat (8) @(negedge ref_clk);
        seen = tdo_out;
        tck = 1'h1;
        repeat (8) @(negedge ref_clk);
        tck = 1'h0;
    endtask

    task automatic t_scan();
        logic [8:0] walk;
        logic [31:0] got;
        logic [1:0] cap;
        logic [4:0] pat;
        logic b;
        walk = 9'h01f;
        pat = 5'h0b;
        got = '0;
        for (int i = 0; i < 9; i++) begin
            scan_step((i == 6) ? 1'h1 : walk[i], b);
        end
        for (int i = 0; i < 32; i++) begin
            scan_step(1'h0, b);
            got[i] = b;
        end
        chk_val("identity", ID_TEST, got);
        chk_bit("scan driving", 1'h0, tdo_oe_n);
        // on to instruction shift, then both captured bits shifted out
        for (int i = 0; i < 6; i++) begin
            scan_step((i < 4) ? 1'h1 : 1'h0, b);
        end
        tdi = 1'h1;
        for (int i = 0; i < 2; i++) begin
            scan_step((i == 1) ? 1'h1 : 1'h0, b);
            cap[i] = b;
        end
        chk_val("ir capture", 32'(sram_pkg::IR_CAPTURE), 32'(cap));
        repeat (4) @(negedge ref_clk);
        chk_bit("scan floats", 1'h1, tdo_oe_n);
        for (int i = 0; i < 4; i++) begin
            scan_step((i < 2) ? 1'h1 : 1'h0, b);
        end
        got = '0;
        // bypass is one stage: input comes back one step later
        for (int i = 0; i < 5; i++) begin
            tdi = pat[i];
            scan_step(1'h0, b);
            got[i] = b;
        end
        chk_val("bypass", 32'h0000_0016, got);
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        chk_bit("reset floats", 1'h1, data_lane_oe_n);
        chk_bit("scan idle", 1'h1, tdo_oe_n);
        chk_bit("awake at reset", 1'h0, sleep_active);
        reset_n = 1'h1;
        repeat (3) @(negedge ref_clk);
        t_write_read();
        t_byte_lanes();
        t_ignored();
        t_sleep();
        t_scan();
        conclude();
    end
endmodule // late_write_sram_tb_top
